// [core/input_alloc_pkg.sv]
// constants of the input signal allocation block
// assumes one system clock; offsets are byte addresses on the AHB-Lite bus
package input_alloc_pkg;
   localparam int NUM_PINS = 8;
   localparam int NUM_FUNC = 13;
   localparam int SEL_WIDTH = 24;
   // register map, byte addresses
   localparam logic [7:0] OFF_SEL_BASE = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h20;
   localparam logic [7:0] OFF_FUNC = 8'h24;
   localparam logic [7:0] OFF_PINS = 8'h28;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   // selection word reset values, pin 1 first
   localparam logic [23:0] SEL_RESET [NUM_PINS] = '{
      24'h323232, 24'h818181, 24'h828282, 24'h222222,
      24'h202020, 24'h212121, 24'h303030, 24'h313131};
   // normally-open codes; bit 7 set means normally-closed
   localparam int NC_BIT = 7;
   localparam logic [7:0] CODE_OFF = 8'h00;
   localparam logic [6:0] CODE_POS = 7'h01;
   localparam logic [6:0] CODE_NEG = 7'h02;
   localparam logic [6:0] CODE_CLR = 7'h04;
   localparam logic [6:0] CODE_STOP = 7'h14;
   localparam logic [6:0] CODE_LAT1 = 7'h20;
   localparam logic [6:0] CODE_LAT2 = 7'h21;
   localparam logic [6:0] CODE_NEAR = 7'h22;
   localparam logic [6:0] CODE_MON1 = 7'h2E;
   localparam logic [6:0] CODE_MON5 = 7'h32;
   // servo-on code, arbitrary value
   localparam logic [6:0] CODE_SON = 7'h03;
   // function indices
   localparam logic [3:0] F_POS = 4'h0;
   localparam logic [3:0] F_NEG = 4'h1;
   localparam logic [3:0] F_CLR = 4'h2;
   localparam logic [3:0] F_STOP = 4'h3;
   localparam logic [3:0] F_LAT1 = 4'h4;
   localparam logic [3:0] F_LAT2 = 4'h5;
   localparam logic [3:0] F_NEAR = 4'h6;
   localparam logic [3:0] F_MON1 = 4'h7;
   localparam logic [3:0] F_MON2 = 4'h8;
   localparam logic [3:0] F_MON4 = 4'hA;
   localparam logic [3:0] F_MON5 = 4'hB;
   localparam logic [3:0] F_SON = 4'hC;
   localparam logic [3:0] F_NONE = 4'hF;
   // latch-correction pins, zero-based
   localparam int LC_FIRST = 4;
   localparam int LC_LAST = 6;
   localparam logic [7:0] MASK_PIN5 = 8'h10;
   localparam logic [7:0] MASK_PIN6 = 8'h20;
   localparam logic [7:0] MASK_PIN7 = 8'h40;
   // protection alarm codes and status layout
   localparam logic [7:0] ALARM_MAIN = 8'h21;
   localparam logic [3:0] SUB_DUP = 4'h0;
   localparam logic [3:0] SUB_PAIR = 4'h1;
   localparam logic [3:0] SUB_POL = 4'h2;
   localparam logic [3:0] SUB_NUM = 4'h3;
   localparam logic [3:0] SUB_LATCH = 4'h8;
   localparam int STAT_ALARM_BIT = 31;
   localparam int STAT_MAIN_LSB = 8;
   // control modes, gray ordered
   typedef enum logic [1:0] {
      MODE_POSITION = 2'h0,
      MODE_VELOCITY = 2'h1,
      MODE_TORQUE = 2'h3,
      MODE_FULL_CLOSED = 2'h2
   } mode_type;
endpackage

// [core/input_signal_allocation.sv]
// input signal allocation: maps eight photocoupler pins onto functions
// assumes AHB-Lite word transfers, async pins, control_mode on hclk
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// R1: each pin has a 24-bit selection word, one byte per control mode
// R2: codes 01h/81h positive inhibit, 02h/82h negative inhibit
// R3: alarm clear 04h only; forced alarm 14h or 94h
// R4: latch one 20h, latch two 21h, normally-open only
// R5: near origin 22h/A2h; monitors one to five 2Eh-32h, bit 7 closed
// R6: open polarity active when conducting; closed active when off
// R7: software writes only table codes; 00h disables a pin
// R8: one function on several pins raises error 33.0
// R9: one pin per function across modes; polarity must match
// R10: listed monitor pairs configured together raise error 33.1
// R11: alarm clear with closed polarity raises error 33.3
// R12: latch one only on pin 5, latch two only on pin 6, else 33.8
// R13: near origin on 6/7, positive on 5/7, negative on 5/6 give 33.8
// R14: pins 5-7, when used, need a function in all three modes
// R15: pins 5-7 take only normally-open codes, else 33.8
// R16: pins 5, 6 and 7 also feed a latch-correction path
// R17: function state is on when active, after polarity applied
// R18: software should pick closed polarity for inhibits and forced alarm
// R19: pins pass two synchroniser flip-flops and an output register; active mode picks the selection byte
// R20: errors checked after selection writes, latched until reset
module input_signal_allocation (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [1:0] control_mode,
   input wire logic input_pin_1,
   input wire logic input_pin_2,
   input wire logic input_pin_3,
   input wire logic input_pin_4,
   input wire logic input_pin_5,
   input wire logic input_pin_6,
   input wire logic input_pin_7,
   input wire logic input_pin_8,
   output logic positive_travel_inhibit,
   output logic negative_travel_inhibit,
   output logic alarm_clear_input,
   output logic forced_alarm,
   output logic latch_input_one,
   output logic latch_input_two,
   output logic near_origin,
   output logic monitor_input_one,
   output logic monitor_input_two,
   output logic monitor_input_three,
   output logic monitor_input_four,
   output logic monitor_input_five,
   output logic external_servo_on,
   output logic latch_correction_5,
   output logic latch_correction_6,
   output logic latch_correction_7,
   output logic protection_alarm,
   output logic [3:0] alarm_sub_code
);

   // code to function index; F_NONE if unknown
   function automatic logic [3:0] func_id(input logic [6:0] c);
      logic [3:0] id;
      id = input_alloc_pkg::F_NONE;
      if (c == input_alloc_pkg::CODE_POS) begin
         id = input_alloc_pkg::F_POS;
      end else if (c == input_alloc_pkg::CODE_NEG) begin
         id = input_alloc_pkg::F_NEG;
      end else if (c == input_alloc_pkg::CODE_CLR) begin
         id = input_alloc_pkg::F_CLR;
      end else if (c == input_alloc_pkg::CODE_STOP) begin
         id = input_alloc_pkg::F_STOP;
      end else if (c == input_alloc_pkg::CODE_LAT1) begin
         id = input_alloc_pkg::F_LAT1;
      end else if (c == input_alloc_pkg::CODE_LAT2) begin
         id = input_alloc_pkg::F_LAT2;
      end else if (c == input_alloc_pkg::CODE_NEAR) begin
         id = input_alloc_pkg::F_NEAR;
      end else if (c == input_alloc_pkg::CODE_SON) begin
         id = input_alloc_pkg::F_SON;
      end else if (c >= input_alloc_pkg::CODE_MON1 &&
                   c <= input_alloc_pkg::CODE_MON5) begin
         id = 4'(c - input_alloc_pkg::CODE_MON1) + input_alloc_pkg::F_MON1;
      end
      return id;
   endfunction

   // functions with no closed code
   function automatic logic open_only(input logic [3:0] id);
      return id == input_alloc_pkg::F_CLR ||
             id == input_alloc_pkg::F_LAT1 ||
             id == input_alloc_pkg::F_LAT2;
   endfunction

   logic [23:0] sel_reg [input_alloc_pkg::NUM_PINS];
   logic [7:0] sync1_reg;
   logic [7:0] sync2_reg;
   logic [7:0] pins_raw;
   logic [12:0] func_reg;
   logic [12:0] func_next;
   logic [2:0] lcorr_reg;
   logic alarm_reg;
   logic [3:0] sub_reg;
   logic check_reg;
   logic err_any;
   logic [3:0] err_sub;
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rd_next;
   logic addr_ok;
   logic [1:0] mode_byte;
   logic [7:0] pin_mask [input_alloc_pkg::NUM_FUNC];
   logic [12:0] seen_open;
   logic [12:0] seen_closed;
   logic bad_code;
   logic clr_closed;
   logic lc_partial;
   logic lc_closed;

   assign pins_raw = {input_pin_8, input_pin_7, input_pin_6, input_pin_5,
                      input_pin_4, input_pin_3, input_pin_2, input_pin_1};

   // two-stage synchronisers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_reg <= 8'h00;
         sync2_reg <= 8'h00;
      end else begin
         sync1_reg <= pins_raw; // R19
         sync2_reg <= sync1_reg;
      end
   end

   // full-closed uses the position byte
   always_comb begin
      unique case (input_alloc_pkg::mode_type'(control_mode))
         input_alloc_pkg::MODE_VELOCITY: mode_byte = 2'h1; // R19
         input_alloc_pkg::MODE_TORQUE: mode_byte = 2'h2;
         input_alloc_pkg::MODE_POSITION,
         input_alloc_pkg::MODE_FULL_CLOSED: mode_byte = 2'h0;
      endcase
   end

   // routing by the active mode's code
   always_comb begin
      logic [7:0] c;
      logic [3:0] id;
      c = 8'h00;
      id = input_alloc_pkg::F_NONE;
      func_next = 13'h0000;
      for (int p = 0; p < input_alloc_pkg::NUM_PINS; p++) begin
         c = sel_reg[p][8*mode_byte +: 8]; // R1
         id = func_id(c[6:0]); // R2 R3 R4 R5
         if (c != input_alloc_pkg::CODE_OFF &&
             id != input_alloc_pkg::F_NONE) begin
            // conducting xor closed bit gives on
            if (sync2_reg[p] ^ c[input_alloc_pkg::NC_BIT]) begin // R6 R17
               func_next[id] = 1'b1;
            end
         end
      end
   end

   // registered function states and latch path
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         func_reg <= 13'h0000;
         lcorr_reg <= 3'h0;
      end else begin
         func_reg <= func_next;
         lcorr_reg <= sync2_reg[input_alloc_pkg::LC_LAST:
                                input_alloc_pkg::LC_FIRST]; // R16
      end
   end

   assign positive_travel_inhibit = func_reg[input_alloc_pkg::F_POS];
   assign negative_travel_inhibit = func_reg[input_alloc_pkg::F_NEG];
   assign alarm_clear_input = func_reg[input_alloc_pkg::F_CLR];
   assign forced_alarm = func_reg[input_alloc_pkg::F_STOP];
   assign latch_input_one = func_reg[input_alloc_pkg::F_LAT1];
   assign latch_input_two = func_reg[input_alloc_pkg::F_LAT2];
   assign near_origin = func_reg[input_alloc_pkg::F_NEAR];
   assign monitor_input_one = func_reg[input_alloc_pkg::F_MON1];
   assign monitor_input_two = func_reg[input_alloc_pkg::F_MON2];
   assign monitor_input_three = func_reg[9];
   assign monitor_input_four = func_reg[input_alloc_pkg::F_MON4];
   assign monitor_input_five = func_reg[input_alloc_pkg::F_MON5];
   assign external_servo_on = func_reg[input_alloc_pkg::F_SON];
   assign latch_correction_5 = lcorr_reg[0];
   assign latch_correction_6 = lcorr_reg[1];
   assign latch_correction_7 = lcorr_reg[2];

   // survey of every word in every mode
   always_comb begin
      logic [7:0] c;
      logic [3:0] id;
      logic [1:0] used;
      c = 8'h00;
      id = input_alloc_pkg::F_NONE;
      used = 2'h0;
      seen_open = 13'h0000;
      seen_closed = 13'h0000;
      bad_code = 1'b0;
      clr_closed = 1'b0;
      lc_partial = 1'b0;
      lc_closed = 1'b0;
      for (int f = 0; f < input_alloc_pkg::NUM_FUNC; f++) begin
         pin_mask[f] = 8'h00;
      end
      for (int p = 0; p < input_alloc_pkg::NUM_PINS; p++) begin
         used = 2'h0;
         for (int m = 0; m < 3; m++) begin
            c = sel_reg[p][8*m +: 8];
            id = func_id(c[6:0]);
            if (c != input_alloc_pkg::CODE_OFF) begin
               used = used + 2'h1;
               if (id == input_alloc_pkg::F_NONE) begin
                  bad_code = 1'b1; // R7
               end else begin
                  pin_mask[id][p] = 1'b1;
                  if (c[input_alloc_pkg::NC_BIT]) begin
                     seen_closed[id] = 1'b1;
                     if (id == input_alloc_pkg::F_CLR) begin
                        clr_closed = 1'b1; // R11
                     end else if (open_only(id)) begin
                        bad_code = 1'b1; // R4
                     end
                     if (p >= input_alloc_pkg::LC_FIRST &&
                         p <= input_alloc_pkg::LC_LAST) begin
                        lc_closed = 1'b1; // R15
                     end
                  end else begin
                     seen_open[id] = 1'b1;
                  end
               end
            end
         end
         // a used latch pin needs all modes
         if (p >= input_alloc_pkg::LC_FIRST &&
             p <= input_alloc_pkg::LC_LAST &&
             used != 2'h0 && used != 2'h3) begin
            lc_partial = 1'b1; // R14
         end
      end
   end

   // error classes, highest priority reported
   always_comb begin
      logic dup;
      logic pair;
      logic pol;
      logic lat;
      dup = 1'b0;
      pol = 1'b0;
      for (int f = 0; f < input_alloc_pkg::NUM_FUNC; f++) begin
         // on more than one pin
         if ((pin_mask[f] & (pin_mask[f] - 8'h01)) != 8'h00) begin
            dup = 1'b1; // R8 R9
         end
         if (seen_open[f] && seen_closed[f]) begin
            pol = 1'b1; // R9
         end
      end
      pair = (pin_mask[input_alloc_pkg::F_MON1] != 8'h00 &&
              pin_mask[input_alloc_pkg::F_LAT1] != 8'h00) ||
             (pin_mask[input_alloc_pkg::F_MON2] != 8'h00 &&
              pin_mask[input_alloc_pkg::F_LAT2] != 8'h00) ||
             (pin_mask[input_alloc_pkg::F_MON4] != 8'h00 &&
              pin_mask[input_alloc_pkg::F_SON] != 8'h00) ||
             (pin_mask[input_alloc_pkg::F_MON5] != 8'h00 &&
              pin_mask[input_alloc_pkg::F_STOP] != 8'h00); // R10
      lat = (pin_mask[input_alloc_pkg::F_LAT1] &
             ~input_alloc_pkg::MASK_PIN5) != 8'h00 || // R12
            (pin_mask[input_alloc_pkg::F_LAT2] &
             ~input_alloc_pkg::MASK_PIN6) != 8'h00 ||
            (pin_mask[input_alloc_pkg::F_NEAR] &
             (input_alloc_pkg::MASK_PIN6 |
              input_alloc_pkg::MASK_PIN7)) != 8'h00 || // R13
            (pin_mask[input_alloc_pkg::F_POS] &
             (input_alloc_pkg::MASK_PIN5 |
              input_alloc_pkg::MASK_PIN7)) != 8'h00 ||
            (pin_mask[input_alloc_pkg::F_NEG] &
             (input_alloc_pkg::MASK_PIN5 |
              input_alloc_pkg::MASK_PIN6)) != 8'h00 ||
            lc_partial || lc_closed; // R14 R15
      err_any = dup || pair || pol || clr_closed || bad_code || lat;
      if (dup) begin
         err_sub = input_alloc_pkg::SUB_DUP;
      end else if (pair) begin
         err_sub = input_alloc_pkg::SUB_PAIR;
      end else if (pol) begin
         err_sub = input_alloc_pkg::SUB_POL;
      end else if (clr_closed || bad_code) begin
         err_sub = input_alloc_pkg::SUB_NUM;
      end else begin
         err_sub = input_alloc_pkg::SUB_LATCH;
      end
   end

   // check after each selection write and reset; sticky so a drive
   // never silently recovers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         check_reg <= 1'b1;
         alarm_reg <= 1'b0;
         sub_reg <= 4'h0;
      end else begin
         check_reg <= wr_pend_reg && addr_ok &&
                      wr_addr_reg < input_alloc_pkg::OFF_STATUS;
         if (check_reg && err_any && !alarm_reg) begin
            alarm_reg <= 1'b1; // R20
            sub_reg <= err_sub;
         end
      end
   end

   assign protection_alarm = alarm_reg;
   assign alarm_sub_code = sub_reg;

   // bus slave: zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_reg;
   assign addr_ok = wr_addr_reg[1:0] == 2'h0;

   // address phase capture for writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end else if (hready) begin
         wr_pend_reg <= hsel && htrans[1] && hwrite &&
                        hsize == input_alloc_pkg::HSIZE_WORD &&
                        haddr[31:8] == 24'h000000;
         wr_addr_reg <= haddr[7:0];
      end
   end

   // data phase write; upper byte dropped
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int p = 0; p < input_alloc_pkg::NUM_PINS; p++) begin
            sel_reg[p] <= input_alloc_pkg::SEL_RESET[p];
         end
      end else if (wr_pend_reg && addr_ok &&
                   wr_addr_reg < input_alloc_pkg::OFF_STATUS) begin
         sel_reg[wr_addr_reg[4:2]] <= hwdata[23:0]; // R1
      end
   end

   // read mux in address phase, registered for data phase
   always_comb begin
      rd_next = 32'h00000000;
      if (haddr[1:0] == 2'h0 && haddr[31:8] == 24'h000000) begin
         if (haddr[7:0] < input_alloc_pkg::OFF_STATUS) begin
            rd_next = {8'h00, sel_reg[haddr[4:2]]};
         end else if (haddr[7:0] == input_alloc_pkg::OFF_STATUS) begin
            rd_next[input_alloc_pkg::STAT_ALARM_BIT] = alarm_reg;
            rd_next[input_alloc_pkg::STAT_MAIN_LSB +: 8] =
               input_alloc_pkg::ALARM_MAIN;
            rd_next[3:0] = sub_reg;
         end else if (haddr[7:0] == input_alloc_pkg::OFF_FUNC) begin
            rd_next = {19'h00000, func_reg};
         end else if (haddr[7:0] == input_alloc_pkg::OFF_PINS) begin
            rd_next = {24'h000000, sync2_reg};
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_reg <= 32'h00000000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         rdata_reg <= rd_next;
      end
   end

endmodule

`default_nettype wire

// [bench/input_alloc_chk.sv]
// assertion checker for the input signal allocation block
// bound to the top module; sees its ports only
`timescale 1ns/1ns
`default_nettype none
module input_alloc_chk (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic input_pin_5,
   input wire logic input_pin_6,
   input wire logic input_pin_7,
   input wire logic latch_correction_5,
   input wire logic latch_correction_6,
   input wire logic latch_correction_7,
   input wire logic protection_alarm,
   input wire logic [3:0] alarm_sub_code
);
   logic [1:0] up_cnt;
   logic wr_sel;
   // cycles since reset release, guards $past
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         up_cnt <= 2'h0;
      end else if (up_cnt != 2'h3) begin
         up_cnt <= up_cnt + 2'h1;
      end
   end
   // write address phase to a selection word
   assign wr_sel = hsel && hready && htrans[1] && hwrite && haddr[31:5] == 0;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // read address phase, then its data phase
   sequence s_sel_read;
      (hsel && hready && htrans[1] && !hwrite && haddr[31:5] == 0) ##1 1'b1;
   endsequence
   sequence s_gap_read;
      (hsel && hready && htrans[1] && !hwrite && haddr >= 32'h2C) ##1 1'b1;
   endsequence
   property p_bus_okay;
      hreadyout && !hresp;
   endproperty
   a_bus_okay: assert property (p_bus_okay)
      else $error("bus answer not ready or not okay");
   property p_sel_upper;
      s_sel_read |-> hrdata[31:24] == 8'h00;
   endproperty
   a_sel_upper: assert property (p_sel_upper)
      else $error("selection word upper byte not zero");
   property p_gap_zero;
      s_gap_read |-> hrdata == 32'h0;
   endproperty
   a_gap_zero: assert property (p_gap_zero)
      else $error("unmapped read not zero");
   property p_alarm_sticky;
      protection_alarm |=> protection_alarm [*3];
   endproperty
   a_alarm_sticky: assert property (p_alarm_sticky)
      else $error("alarm dropped without reset");
   property p_sub_hold;
      protection_alarm |=> $stable(alarm_sub_code);
   endproperty
   a_sub_hold: assert property (p_sub_hold)
      else $error("sub-code changed while alarm held");
   property p_sub_idle;
      !protection_alarm |-> alarm_sub_code == 4'h0;
   endproperty
   a_sub_idle: assert property (p_sub_idle)
      else $error("sub-code set without alarm");
   property p_sub_class;
      protection_alarm |-> alarm_sub_code inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h8};
   endproperty
   a_sub_class: assert property (p_sub_class)
      else $error("sub-code outside the error classes");
   property p_alarm_cause;
      $rose(protection_alarm) |-> $past(wr_sel, 2) || $past(wr_sel, 3);
   endproperty
   a_alarm_cause: assert property (p_alarm_cause)
      else $error("alarm without a selection write");
   property p_latch_path;
      up_cnt == 2'h3 |-> {latch_correction_7, latch_correction_6,
         latch_correction_5} == $past({input_pin_7, input_pin_6, input_pin_5}, 3);
   endproperty
   a_latch_path: assert property (p_latch_path)
      else $error("latch path lag wrong");
endmodule
bind input_signal_allocation input_alloc_chk chk_u (.hclk(hclk),
   .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .input_pin_5(input_pin_5), .input_pin_6(input_pin_6),
   .input_pin_7(input_pin_7), .latch_correction_5(latch_correction_5),
   .latch_correction_6(latch_correction_6),
   .latch_correction_7(latch_correction_7),
   .protection_alarm(protection_alarm), .alarm_sub_code(alarm_sub_code));
`default_nettype wire

// [bench/photo_inputs.sv]
// photocoupler model: eight isolated inputs fed from field switches
// assumes the bench gives each coupler's conduction state
`timescale 1ns/1ns
`default_nettype none
module photo_inputs (
   input wire logic [7:0] conduct,
   output logic [7:0] pin
);
   // couplers switch late, unrelated to hclk; 1 = conducting
   initial pin = 8'h00;
   always @(conduct) begin
      pin <= #13 conduct;
   end
endmodule
`default_nettype wire

// [bench/input_signal_allocation_tb.sv]
// self-checking bench for the input signal allocation block
// assumes the checker and coupler model are compiled with it
`timescale 1ns/1ns
`default_nettype none
module input_signal_allocation_tb;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, protection_alarm;
   logic [31:0] haddr, hwdata, hrdata, rd, r;
   logic [1:0] htrans, control_mode;
   logic [2:0] hsize, lcor;
   logic [7:0] conduct, pin;
   logic [12:0] func;
   logic [3:0] alarm_sub_code;
   logic [23:0] sel_m [8];
   logic [6:0] fcode [13] = '{7'h01, 7'h02, 7'h04, 7'h14, 7'h20, 7'h21,
      7'h22, 7'h2E, 7'h2F, 7'h30, 7'h31, 7'h32, input_alloc_pkg::CODE_SON};
   logic [1:0] modes [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
   int err_count, compares, seed, k, m;
   photo_inputs coupler_u (.conduct(conduct), .pin(pin));
   input_signal_allocation dut_u (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .control_mode(control_mode), .input_pin_1(pin[0]),
      .input_pin_2(pin[1]), .input_pin_3(pin[2]), .input_pin_4(pin[3]),
      .input_pin_5(pin[4]), .input_pin_6(pin[5]), .input_pin_7(pin[6]),
      .input_pin_8(pin[7]), .positive_travel_inhibit(func[0]),
      .negative_travel_inhibit(func[1]), .alarm_clear_input(func[2]),
      .forced_alarm(func[3]), .latch_input_one(func[4]),
      .latch_input_two(func[5]), .near_origin(func[6]),
      .monitor_input_one(func[7]), .monitor_input_two(func[8]),
      .monitor_input_three(func[9]), .monitor_input_four(func[10]),
      .monitor_input_five(func[11]), .external_servo_on(func[12]),
      .latch_correction_5(lcor[0]), .latch_correction_6(lcor[1]),
      .latch_correction_7(lcor[2]), .protection_alarm(protection_alarm),
      .alarm_sub_code(alarm_sub_code));
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   // reference routing; full-closed uses the position byte
   function automatic logic [12:0] exp_funcs(input logic [7:0] lv,
      input logic [1:0] md);
      logic [12:0] e;
      logic [7:0] c;
      int b;
      e = '0;
      b = (md == 2'h1) ? 1 : (md == 2'h3) ? 2 : 0;
      for (int p = 0; p < 8; p++) begin
         c = 8'(sel_m[p] >> (8 * b));
         for (int f = 0; f < 13; f++) begin
            if (c != 8'h00 && c[6:0] == fcode[f]) begin
               e[f] = e[f] | (lv[p] ^ c[7]);
            end
         end
      end
      return e;
   endfunction
   task check(input logic [31:0] got, input logic [31:0] exp,
      input string what);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t %s", $time, what);
      end
   endtask
   task stop_test;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // one AHB-Lite transfer; read data in rd
   task bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
      input logic [2:0] sz);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= sz;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task do_reset;
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      sel_m = input_alloc_pkg::SEL_RESET;
   endtask
   // junk upper byte must be dropped
   task wr_sel(input int p, input logic [23:0] v);
      bus(1'b1, 32'(4 * p), {8'hA5, v}, input_alloc_pkg::HSIZE_WORD);
      sel_m[p] = v;
   endtask
   task run_case(input int pa, input logic [23:0] va, input int pb,
      input logic [23:0] vb, input logic alm, input logic [3:0] sub);
      do_reset;
      wr_sel(pa, va);
      wr_sel(pb, vb);
      repeat (4) @(posedge hclk);
      bus(1'b0, 32'h20, 32'h0, input_alloc_pkg::HSIZE_WORD);
      check({protection_alarm, alarm_sub_code, rd[31], rd[3:0]},
         {alm, sub, alm, sub}, "alarm class");
      $display("alarm case %0d/%0d done", pa + 1, pb + 1);
   endtask
   // random pin levels in each mode vs the reference
   task route(input int n);
      for (m = 0; m < 4; m++) begin
         control_mode <= modes[m];
         for (k = 0; k < n; k++) begin
            @(posedge hclk);
            conduct <= 8'($random(seed));
            repeat (5) @(posedge hclk);
            check({19'h0, func}, {19'h0, exp_funcs(conduct, modes[m])},
               "function map");
            check({29'h0, lcor}, {29'h0, conduct[6:4]}, "latch path");
         end
      end
   endtask
   initial begin
      #(20000 * 50);
      err_count++;
      stop_test;
   end
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h0;
      hwdata = 32'h0;
      control_mode = 2'h0;
      conduct = 8'h00;
      err_count = 0;
      compares = 0;
      seed = 32'hcd7266d3;
      sel_m = input_alloc_pkg::SEL_RESET;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      for (k = 0; k < 8; k++) begin
         bus(1'b0, 32'(4 * k), 32'h0, input_alloc_pkg::HSIZE_WORD);
         check(rd, {8'h00, input_alloc_pkg::SEL_RESET[k]}, "reset value");
      end
      r = $random(seed);
      wr_sel(6, r[23:0]);
      bus(1'b1, 32'h18, ~r, 3'h0);
      bus(1'b1, 32'h20, 32'hFFFFFFFF, input_alloc_pkg::HSIZE_WORD);
      bus(1'b0, 32'h18, 32'h0, input_alloc_pkg::HSIZE_WORD);
      check(rd, {8'h00, r[23:0]}, "word readback");
      bus(1'b0, 32'h2C, 32'h0, input_alloc_pkg::HSIZE_WORD);
      check(rd, 32'h0, "unmapped read");
      $display("register test done");
      do_reset;
      route(3);
      wr_sel(0, 24'h049400);
      route(3);
      $display("routing test done");
      run_case(7, 24'h818181, 7, 24'h818181, 1'b1, 4'h0);
      run_case(1, 24'h008181, 7, 24'h810000, 1'b1, 4'h0);
      run_case(1, 24'h818101, 1, 24'h818101, 1'b1, 4'h2);
      run_case(6, 24'h2E2E2E, 6, 24'h2E2E2E, 1'b1, 4'h1);
      run_case(6, 24'h141414, 6, 24'h141414, 1'b1, 4'h1);
      run_case(7, 24'h848484, 7, 24'h848484, 1'b1, 4'h3);
      run_case(7, 24'h050505, 7, 24'h050505, 1'b1, 4'h3);
      run_case(4, 24'hA0A0A0, 4, 24'hA0A0A0, 1'b1, 4'h3);
      run_case(4, 24'h000000, 7, 24'h202020, 1'b1, 4'h8);
      run_case(3, 24'h000000, 5, 24'h222222, 1'b1, 4'h8);
      run_case(1, 24'h000000, 4, 24'h010101, 1'b1, 4'h8);
      run_case(2, 24'h000000, 5, 24'h020202, 1'b1, 4'h8);
      run_case(6, 24'h000030, 6, 24'h000030, 1'b1, 4'h8);
      run_case(6, 24'hB0B0B0, 6, 24'hB0B0B0, 1'b1, 4'h8);
      run_case(3, 24'hA2A2A2, 0, 24'hB2B2B2, 1'b0, 4'h0);
      stop_test;
   end
endmodule
`default_nettype wire
